// ===== src/cef_regs.vh
`ifndef CEF_REGS_VH
`define CEF_REGS_VH
// register offsets (word addresses of the plain register port)
`define CEF_ADDR_W 4
`define CEF_OFS_FLAG 4'h0
`define CEF_OFS_MASK 4'h1
// flag register field positions
`define CEF_BIT_TX_BUS_OFF 13
`define CEF_BIT_TX_PASSIVE 12
`define CEF_BIT_RX_PASSIVE 11
`define CEF_BIT_TX_WARN 10
`define CEF_BIT_RX_WARN 9
`define CEF_BIT_ANY_WARN 8
`define CEF_BIT_INVALID 7
`define CEF_BIT_WAKEUP 6
`define CEF_BIT_ERROR 5
`define CEF_BIT_FIFO 3
`define CEF_BIT_OVERFLOW 2
`define CEF_BIT_RX_BUF 1
`define CEF_BIT_TX_BUF 0
// masks and reset values
`define CEF_STICKY_MASK 16'h00EF
`define CEF_STATE_MASK 16'h3F00
`define CEF_FLAG_RESET 16'h0000
`define CEF_MASK_RESET 16'h0000
`define CEF_ZERO16 16'h0000
// widths and reset values of the internal state
`define CEF_REG_W 16
`define CEF_STATE_W 6
`define CEF_STATE_RESET 6'h00
`define CEF_IRQ_RESET 1'b0
`endif

// ===== src/cef_error_flags.v
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "cef_regs.vh"
module cef_error_flags (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // register port
  input wire [`CEF_ADDR_W-1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // error states from the protocol engine (levels)
  input wire tx_bus_off_state,
  input wire tx_error_passive_state,
  input wire rx_error_passive_state,
  input wire tx_error_warning_state,
  input wire rx_error_warning_state,
  // event pulses from the protocol engine
  input wire invalid_message_evt,
  input wire bus_wakeup_evt,
  input wire fifo_almost_full_evt,
  input wire rx_overflow_evt,
  input wire rx_buffer_evt,
  input wire tx_buffer_evt,
  // interrupt
  output reg can_irq
);

  // timing at a glance:
  // an event pulse sampled at one edge shows in the flag at that same edge
  // the interrupt output moves at that same edge as well
  // a read strobe sampled at an edge returns the flag as it stood before it
  // so a read launched right after an event already sees the set bit
  // read data stand for one cycle only and are zero at all other times
  // state levels are copied at every edge, never latched and never written
  // the combined error flag marks entry into a state, not leaving one
  // a clear and a set of one flag in one cycle leave the flag set
  // writes to the gap positions and to the state field have no effect
  // the mask has the flag layout; only sticky positions can be unmasked
  // limitation: levels are taken as same-clock signals, with no synchroniser
  // a slower engine must present its levels already registered on mclk
  // limitation: an engine that comes out of reset in a state sets bit 5
  // trade-off: read data are registered, costing one cycle of latency
  // in return the read port has no combinational path from the address
  // trade-off: the interrupt tracks the new mask, so masking drops it at once

  // sticky and state layouts as constants so per-bit loops can index them
  localparam [`CEF_REG_W-1:0] STICKY = `CEF_STICKY_MASK;
  localparam [`CEF_REG_W-1:0] STATE = `CEF_STATE_MASK;

  // software-visible storage
  reg [15:0] can_interrupt_flag_status;
  reg [15:0] irq_mask;

  // error-state levels as they stood at the previous edge
  reg [`CEF_STATE_W-1:0] state_prev;

  // combinational next values of the flag, mask, read data and interrupt registers
  reg [15:0] next_flag;
  reg [15:0] next_mask;
  reg [15:0] next_rdata;
  reg next_irq;

  // decoded strobes
  wire flag_wr;
  wire mask_wr;
  wire flag_rd;
  wire mask_rd;

  // error-state view
  wire any_error_warning_state;
  wire error_entry;
  wire [`CEF_STATE_W-1:0] state_now;
  wire [`CEF_STATE_W-1:0] state_entry;
  wire [15:0] state_field;

  // event view
  wire [15:0] hw_set;
  wire [15:0] soft_clear;
  wire [15:0] sticky_next;

  // loop index for the per-bit generate blocks
  genvar g;

  // address decode shared by the write and the read paths
  function cef_hit;
    input [`CEF_ADDR_W-1:0] addr;
    input [`CEF_ADDR_W-1:0] ofs;
    begin
      cef_hit = (addr == ofs);
    end
  endfunction

  // entry into a state: level up now, down at the edge before
  function cef_rise;
    input now_lvl;
    input old_lvl;
    begin
      cef_rise = now_lvl & ~old_lvl;
    end
  endfunction

  // write decode; the master never raises both strobes at once
  assign flag_wr = reg_wr & cef_hit(reg_addr, `CEF_OFS_FLAG);
  assign mask_wr = reg_wr & cef_hit(reg_addr, `CEF_OFS_MASK);

  // read decode; reading has no side effect on any flag
  assign flag_rd = reg_rd & cef_hit(reg_addr, `CEF_OFS_FLAG);
  assign mask_rd = reg_rd & cef_hit(reg_addr, `CEF_OFS_MASK);

  // combined warning is a plain or of both directions
  assign any_error_warning_state = tx_error_warning_state | rx_error_warning_state;

  // the six state levels, ordered as they sit in the flag register
  assign state_now = {tx_bus_off_state,
                      tx_error_passive_state,
                      rx_error_passive_state,
                      tx_error_warning_state,
                      rx_error_warning_state,
                      any_error_warning_state};

  // state bits follow the engine and are never written by software
  // transmitter bus-off
  assign state_field[`CEF_BIT_TX_BUS_OFF] = tx_bus_off_state;
  // transmitter error-passive
  assign state_field[`CEF_BIT_TX_PASSIVE] = tx_error_passive_state;
  // receiver error-passive
  assign state_field[`CEF_BIT_RX_PASSIVE] = rx_error_passive_state;
  // transmitter error-warning
  assign state_field[`CEF_BIT_TX_WARN] = tx_error_warning_state;
  // receiver error-warning
  assign state_field[`CEF_BIT_RX_WARN] = rx_error_warning_state;
  // either direction in error-warning
  assign state_field[`CEF_BIT_ANY_WARN] = any_error_warning_state;

  // positions outside the state field carry nothing
  generate
    for (g = 0; g < `CEF_REG_W; g = g + 1) begin : gen_state_gap
      if (!STATE[g]) begin : gen_zero
        assign state_field[g] = 1'b0;
      end
    end
  endgenerate

  // entry detection, one bit per state level
  generate
    for (g = 0; g < `CEF_STATE_W; g = g + 1) begin : gen_entry
      assign state_entry[g] = cef_rise(state_now[g], state_prev[g]);
    end
  endgenerate

  // leaving a state raises nothing; only entering one does
  assign error_entry = |state_entry;

  // hardware set requests, one per sticky flag
  // invalid message seen on the bus
  assign hw_set[`CEF_BIT_INVALID] = invalid_message_evt;
  // wake-up activity on the bus
  assign hw_set[`CEF_BIT_WAKEUP] = bus_wakeup_evt;
  // entry into any error state
  assign hw_set[`CEF_BIT_ERROR] = error_entry;
  // receive fifo almost full
  assign hw_set[`CEF_BIT_FIFO] = fifo_almost_full_evt;
  // receive buffer overflow
  assign hw_set[`CEF_BIT_OVERFLOW] = rx_overflow_evt;
  // message received into a buffer
  assign hw_set[`CEF_BIT_RX_BUF] = rx_buffer_evt;
  // transmit buffer done
  assign hw_set[`CEF_BIT_TX_BUF] = tx_buffer_evt;

  // no set request outside the sticky positions
  generate
    for (g = 0; g < `CEF_REG_W; g = g + 1) begin : gen_set_gap
      if (!STICKY[g]) begin : gen_zero
        assign hw_set[g] = 1'b0;
      end
    end
  endgenerate

  // a written zero clears, a written one keeps; only sticky positions take it
  assign soft_clear = flag_wr ? (~reg_wdata & STICKY) : `CEF_ZERO16;

  // per flag: hardware set wins over a clear in the same cycle
  // so an event never slips past software that is clearing its flag
  generate
    for (g = 0; g < `CEF_REG_W; g = g + 1) begin : gen_sticky
      assign sticky_next[g] = STICKY[g] & (hw_set[g] | (can_interrupt_flag_status[g] & ~soft_clear[g]));
    end
  endgenerate

  // next flag word: sticky part plus live state part; gaps read zero
  always @* begin
    next_flag = (sticky_next & STICKY) | (state_field & STATE);
  end

  // mask takes writes to the sticky positions only
  always @* begin
    next_mask = irq_mask;
    if (mask_wr) begin
      next_mask = reg_wdata & STICKY;
    end
  end

  // read mux; unmapped addresses and idle cycles return zero
  always @* begin
    next_rdata = `CEF_ZERO16;
    if (flag_rd) begin
      next_rdata = can_interrupt_flag_status;
    end else if (mask_rd) begin
      next_rdata = irq_mask;
    end
  end

  // interrupt follows the new flag and mask, so a clear drops it at once
  always @* begin
    next_irq = |(next_flag & next_mask & STICKY);
  end

  // state history for entry detection
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_prev <= `CEF_STATE_RESET;
    end else begin
      // refreshed at every edge so one entry sets the flag only once
      state_prev <= state_now;
    end
  end

  // flag register
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      can_interrupt_flag_status <= `CEF_FLAG_RESET;
    end else begin
      // sticky bits and live state bits load together
      can_interrupt_flag_status <= next_flag;
    end
  end

  // mask register; reset leaves every source masked
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= `CEF_MASK_RESET;
    end else begin
      irq_mask <= next_mask;
    end
  end

  // read data register, valid only in the cycle after the strobe
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `CEF_ZERO16;
    end else begin
      // zero outside that cycle keeps a shared read bus quiet
      reg_rdata <= next_rdata;
    end
  end

  // level interrupt output straight from a flip-flop
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      can_irq <= `CEF_IRQ_RESET;
    end else begin
      // high while any unmasked sticky flag is set
      can_irq <= next_irq;
    end
  end

endmodule

// ===== sim/cef_bus_model.sv
`timescale 1ns/1ps
// far-side engine: levels {bus_off,tx_pas,rx_pas,tx_warn,rx_warn}, pulses after
module cef_bus_model (
  input wire logic mclk,
  input wire logic [10:0] req,
  output logic [10:0] drv
);
  initial drv = 11'h000;
  // registered like a same-clock engine, so pulses last one cycle
  always @(posedge mclk) drv <= req;
endmodule

// ===== sim/cef_error_flags_monitor.sv
`timescale 1ns/1ps
module cef_error_flags_monitor (
  input wire mclk, rst_n, reg_wr, reg_rd, can_irq, rx_overflow_evt,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_rdata,
  input wire tx_bus_off_state, tx_error_passive_state, rx_error_passive_state,
  input wire tx_error_warning_state, rx_error_warning_state
);
  wire [4:0] st = {tx_bus_off_state, tx_error_passive_state, rx_error_passive_state,
    tx_error_warning_state, rx_error_warning_state};
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // state reaches the flag one edge late, read data one edge later
  sequence flag_rd; reg_rd && reg_addr == 4'h0; endsequence
  bus_off_a: assert property (flag_rd |=> reg_rdata[13] == $past(st[4], 2)) else $error("bit13");
  tx_pas_a: assert property (flag_rd |=> reg_rdata[12] == $past(st[3], 2)) else $error("bit12");
  rx_pas_a: assert property (flag_rd |=> reg_rdata[11] == $past(st[2], 2)) else $error("bit11");
  tx_warn_a: assert property (flag_rd |=> reg_rdata[10] == $past(st[1], 2)) else $error("bit10");
  rx_warn_a: assert property (flag_rd |=> reg_rdata[9] == $past(st[0], 2)) else $error("bit9");
  any_warn_a: assert property (flag_rd |=> reg_rdata[8] == $past(|st[1:0], 2)) else $error("bit8");
  gap_zero_a: assert property (reg_rdata[15:14] == 2'h0 && !reg_rdata[4]) else $error("gap bits");
  ovf_set_a: assert property (rx_overflow_evt ##1 flag_rd |=> reg_rdata[2]) else $error("bit2");
  irq_drop_a: assert property ($fell(can_irq) |-> $past(reg_wr)) else $error("irq drop");
endmodule

// ===== sim/can_error_interrupt_flags_tb.sv
`timescale 1ns/1ps
module can_error_interrupt_flags_tb;
  logic mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, e;
  logic [10:0] req = 11'h000, drv;
  wire [15:0] reg_rdata;
  wire can_irq, tx_bus_off_state, tx_error_passive_state, rx_error_passive_state, tx_error_warning_state,
    rx_error_warning_state, invalid_message_evt, bus_wakeup_evt, fifo_almost_full_evt, rx_overflow_evt,
    rx_buffer_evt, tx_buffer_evt;
  int errors = 0, cmp_count = 0;
  assign {tx_bus_off_state, tx_error_passive_state, rx_error_passive_state, tx_error_warning_state,
    rx_error_warning_state, invalid_message_evt, bus_wakeup_evt, fifo_almost_full_evt, rx_overflow_evt,
    rx_buffer_evt, tx_buffer_evt} = drv;
  always #2.5 mclk = ~mclk;
  cef_error_flags DUT (.*);
  cef_bus_model far (.mclk(mclk), .req(req), .drv(drv));
  task chk(input logic [15:0] s, input logic [15:0] x);
    cmp_count++;
    if (s !== x) begin
      errors++;
      $display("unexpected %0t got %h exp %h", $time, s, x);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge mclk) reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] x);
    @(posedge mclk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge mclk) reg_rd <= 1'b0;
    #1 chk(reg_rdata, x);
  endtask
  task wrap_up;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd(4'h0, 16'h0000);
    rd(4'h9, 16'h0000);
    // one state at a time; entering any state also raises the combined flag
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk) req <= 11'h040 << i;
      repeat (3) @(posedge mclk);
      e = {2'h0, 5'h01 << i, i < 2, 8'h20};
      rd(4'h0, e);
      wr(4'h0, 16'h0000);
      rd(4'h0, e & 16'h3F00);
    end
    @(posedge mclk) req <= 11'h000;
    repeat (3) @(posedge mclk);
    wr(4'h0, 16'h0000);
    e = 16'h0000;
    // pulses accumulate; read follows straight after each pulse
    for (int j = 0; j < 6; j++) begin
      @(posedge mclk) req <= 11'h001 << j;
      @(posedge mclk) req <= 11'h000;
      e = e | (16'h0001 << (j > 3 ? j + 2 : j));
      rd(4'h0, e);
    end
    chk({15'h0000, can_irq}, 16'h0000);
    wr(4'h1, 16'hFFFF);
    rd(4'h1, 16'h00EF);
    chk({15'h0000, can_irq}, 16'h0001);
    wr(4'h0, 16'hFFFF);
    rd(4'h0, 16'h00CF);
    wr(4'h0, 16'hFFFB);
    rd(4'h0, 16'h00CB);
    wr(4'h0, 16'h0000);
    #1 chk({15'h0000, can_irq}, 16'h0000);
    wrap_up;
  end
  initial begin
    #5000;
    errors++;
    wrap_up;
  end
endmodule
bind cef_error_flags cef_error_flags_monitor mon (.*);
